// [design/rps_pkg.sv]
// Constants for the ROM program sequencer
package rps_pkg;
   localparam int ROM_WORD_W = 10;
   localparam int BANK_W = 1;
   localparam int PAGE_W = 5;
   localparam int ADDR_W = 6;
   localparam int PC_W = BANK_W + PAGE_W + ADDR_W;
   localparam int SEQ_LEN = 64;
   localparam int SYNC_STAGES = 2;
   localparam int INT_HOLD_CYCLES = 2;
   localparam logic [BANK_W-1:0] BANK_RESET = 1'h0;
   localparam logic [PAGE_W-1:0] PAGE_RESET = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h3F;
   localparam logic [BANK_W-1:0] SUB_BANK = 1'h0;
   localparam logic [PAGE_W-1:0] SUB_PAGE = 5'h00;
   localparam int BR_OPND_LSB = 0;
   localparam int LPU_OPND_LSB = 0;
   // Circular in-page address order, entry i steps to entry i+1
   localparam logic [ADDR_W-1:0] ADDR_SEQ [SEQ_LEN] = '{
      6'h3F, 6'h3E, 6'h3D, 6'h3B, 6'h37, 6'h2F, 6'h1E, 6'h3C,
      6'h39, 6'h33, 6'h27, 6'h0E, 6'h1D, 6'h3A, 6'h35, 6'h2B,
      6'h16, 6'h2C, 6'h18, 6'h30, 6'h21, 6'h02, 6'h05, 6'h0B,
      6'h17, 6'h2E, 6'h1C, 6'h38, 6'h31, 6'h23, 6'h06, 6'h0D,
      6'h1B, 6'h36, 6'h2D, 6'h1A, 6'h34, 6'h29, 6'h12, 6'h24,
      6'h08, 6'h11, 6'h22, 6'h04, 6'h09, 6'h13, 6'h26, 6'h0C,
      6'h19, 6'h32, 6'h25, 6'h0A, 6'h15, 6'h2A, 6'h14, 6'h28,
      6'h10, 6'h20, 6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h1F};
endpackage

// [design/rps_sync.sv]
// Two-flop level synchroniser for asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module rps_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
      if (srst_in) begin
         meta_d = RESET_VAL;
         sync_d = RESET_VAL;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
   end

   assign sync_out = sync_q;
endmodule // rps_sync
`default_nettype wire

// [design/rps_sequencer.sv]
// Program counter, halt, reset and interrupt front end of the core
//
// Contract
// - Halt input low freezes the address, bank, page, pending load and status registers.
// - Halt release resumes from the frozen state, nothing reinitialised.
// - Reset input is active high; sequencer held in reset while high.
// - Interrupt inputs are asynchronous and accepted at any time.
// - Each program word is ten bits, instruction or constant.
// - Two banks of 32 pages of 64 words each.
// - Bank 0 page 0 is the subroutine area.
// - Counter is bank bit, five page bits, six address bits.
// - Bank and page hold until the program loads new values.
// - Bank takes 0 or 1; page takes 0 through 31.
// - Address is a polynomial counter stepping once per cycle.
// - Address follows the fixed 64-entry tabulated order.
// - Order is circular; execution stays in the current page.
// - Address wrap never carries into page or bank.
// - In-page branch loads low six bits when status set, else sets status.
// - Page load takes operand and inverted channel bit, one cycle late.
`timescale 1ns/10ps
`default_nettype none
module rps_sequencer (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic halt_request_n_in,
   input wire logic ext_interrupt_a_in,
   input wire logic ext_interrupt_b_in,
   input wire logic [rps_pkg::ROM_WORD_W-1:0] instr_word_in,
   input wire logic branch_in_page_in,
   input wire logic load_bank_page_upper_in,
   input wire logic status_flag_in,
   input wire logic bank_select_out_bit_in,
   output logic [rps_pkg::PC_W-1:0] rom_addr_out,
   output logic [rps_pkg::BANK_W-1:0] bank_out,
   output logic [rps_pkg::PAGE_W-1:0] page_out,
   output logic [rps_pkg::ADDR_W-1:0] addr_out,
   output logic subroutine_area_out,
   output logic status_set_out,
   output logic running_out,
   output logic ext_interrupt_a_out,
   output logic ext_interrupt_b_out
);
   import rps_pkg::*;

   logic run_sync;
   logic int_a_sync;
   logic int_b_sync;

   logic [BANK_W-1:0] bank_q;
   logic [BANK_W-1:0] bank_d;
   logic [PAGE_W-1:0] page_q;
   logic [PAGE_W-1:0] page_d;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] addr_d;
   logic lpu_pend_q;
   logic lpu_pend_d;
   logic [BANK_W-1:0] bank_pend_q;
   logic [BANK_W-1:0] bank_pend_d;
   logic [PAGE_W-1:0] page_pend_q;
   logic [PAGE_W-1:0] page_pend_d;
   logic status_set_q;
   logic status_set_d;
   logic int_a_q;
   logic int_a_d;
   logic int_b_q;
   logic int_b_d;
   logic running_q;
   logic running_d;

   logic [ADDR_W-1:0] addr_step;
   logic [ADDR_W-1:0] step_hit [SEQ_LEN];
   logic branch_taken;
   logic load_taken;

   // Halt pin is a plain level; held released during reset
   rps_sync #(.RESET_VAL(1'b1)) u_halt_sync (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .async_in(halt_request_n_in),
      .sync_out(run_sync)
   );

   // Interrupt pins carry levels; edge and priority handling is the core's
   rps_sync #(.RESET_VAL(1'b0)) u_int_a_sync (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .async_in(ext_interrupt_a_in),
      .sync_out(int_a_sync)
   );

   rps_sync #(.RESET_VAL(1'b0)) u_int_b_sync (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .async_in(ext_interrupt_b_in),
      .sync_out(int_b_sync)
   );

   // Table lookup rather than a feedback polynomial keeps the order exact
   genvar gi;
   generate
      for (gi = 0; gi < SEQ_LEN; gi++) begin : g_step
         if (gi == 0) begin : g_first
            assign step_hit[gi] = (addr_q == ADDR_SEQ[gi]) ?
                                  ADDR_SEQ[(gi + 1) % SEQ_LEN] : '0;
         end else begin : g_rest
            assign step_hit[gi] = step_hit[gi-1] |
                                  ((addr_q == ADDR_SEQ[gi]) ?
                                   ADDR_SEQ[(gi + 1) % SEQ_LEN] : '0);
         end
      end
   endgenerate

   // Last entry wraps to first; only the address field sees it
   assign addr_step = step_hit[SEQ_LEN-1];

   // Both decodes are refused while the status flag is clear
   assign branch_taken = branch_in_page_in && status_flag_in;
   assign load_taken = load_bank_page_upper_in && status_flag_in;

   // Halted: address, bank, page and status registers keep their value; synchronisers and level registers still run
   // Branch wins over the step; a skipped branch just steps
   always_comb begin
      addr_d = addr_q;
      if (srst_in) begin
         addr_d = ADDR_RESET;
      end else if (run_sync) begin
         addr_d = addr_step;
         if (branch_taken) begin
            addr_d = instr_word_in[BR_OPND_LSB +: ADDR_W];
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      addr_q <= addr_d;
   end

   // Load waits one cycle; the next word still runs in the old page
   always_comb begin
      bank_d = bank_q;
      page_d = page_q;
      lpu_pend_d = lpu_pend_q;
      bank_pend_d = bank_pend_q;
      page_pend_d = page_pend_q;
      if (srst_in) begin
         bank_d = BANK_RESET;
         page_d = PAGE_RESET;
         lpu_pend_d = 1'b0;
         bank_pend_d = BANK_RESET;
         page_pend_d = PAGE_RESET;
      end else if (run_sync) begin
         lpu_pend_d = 1'b0;
         if (lpu_pend_q) begin
            bank_d = bank_pend_q;
            page_d = page_pend_q;
         end
         // A skipped load changes nothing, status included
         if (load_taken) begin
            lpu_pend_d = 1'b1;
            page_pend_d = instr_word_in[LPU_OPND_LSB +: PAGE_W];
            bank_pend_d = ~bank_select_out_bit_in;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      bank_q <= bank_d;
      page_q <= page_d;
      lpu_pend_q <= lpu_pend_d;
      bank_pend_q <= bank_pend_d;
      page_pend_q <= page_pend_d;
   end

   // One-cycle pulse asking the core to set its status flag
   always_comb begin
      status_set_d = status_set_q;
      if (srst_in) begin
         status_set_d = 1'b0;
      end else if (run_sync) begin
         status_set_d = branch_in_page_in && !status_flag_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      status_set_q <= status_set_d;
   end

   // Levels keep flowing while halted; only sequencer state freezes
   // Reset clears the levels; the interrupt synchronisers clear themselves too, the halt one presets released
   always_comb begin
      int_a_d = int_a_sync;
      int_b_d = int_b_sync;
      running_d = run_sync;
      if (srst_in) begin
         int_a_d = 1'b0;
         int_b_d = 1'b0;
         running_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      int_a_q <= int_a_d;
      int_b_q <= int_b_d;
      running_q <= running_d;
   end

   // Fields come straight from flip-flops; the area flag decodes them
   assign rom_addr_out = {bank_q, page_q, addr_q};
   assign bank_out = bank_q;
   assign page_out = page_q;
   assign addr_out = addr_q;
   assign subroutine_area_out = (bank_q == SUB_BANK) &&
                                (page_q == SUB_PAGE);
   assign status_set_out = status_set_q;
   assign running_out = running_q;
   // Levels shorter than one cycle may be missed; the source holds each level two cycles or more
   assign ext_interrupt_a_out = int_a_q;
   assign ext_interrupt_b_out = int_b_q;
endmodule // rps_sequencer
`default_nettype wire

// [verification/rps_checker.sv]
// Assertion checker for the program sequencer
`timescale 1ns/10ps
`default_nettype none
module rps_checker (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic halt_request_n_in,
   input wire logic ext_interrupt_a_in,
   input wire logic ext_interrupt_a_out,
   input wire logic ext_interrupt_b_in,
   input wire logic ext_interrupt_b_out,
   input wire logic [rps_pkg::ROM_WORD_W-1:0] instr_word_in,
   input wire logic branch_in_page_in,
   input wire logic load_bank_page_upper_in,
   input wire logic status_flag_in,
   input wire logic bank_select_out_bit_in,
   input wire logic [rps_pkg::PC_W-1:0] rom_addr_out,
   input wire logic subroutine_area_out,
   input wire logic [rps_pkg::BANK_W-1:0] bank_out,
   input wire logic [rps_pkg::PAGE_W-1:0] page_out,
   input wire logic [rps_pkg::ADDR_W-1:0] addr_out,
   input wire logic running_out,
   input wire logic status_set_out
);
   import rps_pkg::*;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   function automatic logic [5:0] nxt(logic [5:0] a);
      for (int i = 0; i < SEQ_LEN; i++)
         if (ADDR_SEQ[i] == a) return ADDR_SEQ[(i + 1) % SEQ_LEN];
      return a;
   endfunction
   a_addr_step: assert property (
      !$past(srst_in) && $past(halt_request_n_in, 3)
      && !$past(branch_in_page_in) |->
      rom_addr_out[5:0] == nxt($past(rom_addr_out[5:0])))
      else $error("bad address step");
   a_branch_take: assert property (
      !$past(srst_in) && $past(halt_request_n_in, 3)
      && $past(branch_in_page_in && status_flag_in) |->
      rom_addr_out[5:0] == $past(instr_word_in[5:0])) else $error("bad branch");
   a_skip_pulse: assert property (
      !$past(srst_in) && $past(halt_request_n_in, 3) |-> status_set_out ==
      $past(branch_in_page_in && !status_flag_in)) else $error("bad skip");
   a_page_load: assert property (
      !$past(srst_in) && !$past(srst_in, 2) && $past(halt_request_n_in, 3)
      && $past(halt_request_n_in, 4)
      && $past(load_bank_page_upper_in && status_flag_in, 2) |->
      rom_addr_out[11:6] == {$past(!bank_select_out_bit_in, 2),
      $past(instr_word_in[4:0], 2)}) else $error("bad page load");
   a_page_hold: assert property (
      $changed(rom_addr_out[11:6]) && $past(halt_request_n_in, 4) |->
      $past(load_bank_page_upper_in && status_flag_in, 2) || $past(srst_in))
      else $error("page moved");
   a_halt_freeze: assert property (
      (!halt_request_n_in) [*3] |=> $stable(rom_addr_out))
      else $error("halt not frozen");
   a_int_sync: assert property (
      !$past(srst_in) && !$past(srst_in, 2) && !$past(srst_in, 3) |->
      ext_interrupt_a_out == $past(ext_interrupt_a_in, 3))
      else $error("bad int sync");
   a_sub_area: assert property (
      subroutine_area_out == (rom_addr_out[11:6] == 6'h00))
      else $error("bad sub area");
   a_int_sync_b: assert property (
      !$past(srst_in) && !$past(srst_in, 2) && !$past(srst_in, 3) |->
      ext_interrupt_b_out == $past(ext_interrupt_b_in, 3))
      else $error("bad int b sync");
   a_run_follow: assert property (
      !$past(srst_in) && !$past(srst_in, 2) && !$past(srst_in, 3) |->
      running_out == $past(halt_request_n_in, 3))
      else $error("bad running flag");
   a_field_split: assert property (
      rom_addr_out == {bank_out, page_out, addr_out})
      else $error("bad field split");
   a_halt_status: assert property (
      (!halt_request_n_in) [*3] |=> $stable(status_set_out))
      else $error("status not frozen");
endmodule // rps_checker
bind rps_sequencer rps_checker i_chk (.*);
`default_nettype wire

// [verification/rps_src.sv]
// Interrupt source model, each level held two cycles or more
`timescale 1ns/10ps
`default_nettype none
module rps_src (
   input wire logic sys_clk_in,
   input wire logic [1:0] want_in,
   output logic [1:0] pin_out
);
   logic [1:0] pin_q = 2'h0;
   int held = 2;
   always @(posedge sys_clk_in) begin
      if (want_in != pin_q && held >= 2) begin
         pin_q <= want_in;
         held <= 1;
      end else begin
         held <= held + 1;
      end
   end
   assign pin_out = pin_q;
endmodule // rps_src
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking testbench for the program sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import rps_pkg::*;
   logic sys_clk_in = 1'h0, srst_in = 1'h1, halt_n = 1'h1, branch = 1'h0;
   logic load_bank_page_upper = 1'h0, status = 1'h0, bsel = 1'h0, sub, sset, run, ia, ib;
   logic bank;
   logic [4:0] page;
   logic [1:0] want = 2'h0, ints;
   logic [9:0] instr = 10'h000;
   logic [PC_W-1:0] rom;
   logic [5:0] addr;
   int error_cnt = 0, checks = 0;
   always #10 sys_clk_in = ~sys_clk_in;
   rps_src i_src (.sys_clk_in, .want_in(want), .pin_out(ints));
   rps_sequencer i_dut (.sys_clk_in, .srst_in, .halt_request_n_in(halt_n),
      .ext_interrupt_a_in(ints[0]), .ext_interrupt_b_in(ints[1]),
      .instr_word_in(instr), .branch_in_page_in(branch),
      .load_bank_page_upper_in(load_bank_page_upper), .status_flag_in(status),
      .bank_select_out_bit_in(bsel), .rom_addr_out(rom), .bank_out(bank),
      .page_out(page), .addr_out(addr), .subroutine_area_out(sub),
      .status_set_out(sset), .running_out(run),
      .ext_interrupt_a_out(ia), .ext_interrupt_b_out(ib));
   task automatic chk(string n, logic [11:0] e, logic [11:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
   endtask
   task automatic t_walk;
      logic [5:0] hd [7] = '{6'h3E, 6'h3D, 6'h3B, 6'h37, 6'h2F, 6'h1E, 6'h3C};
      logic [5:0] tl [7] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F};
      for (int i = 1; i <= 64; i++) begin
         cyc(1);
         if (i < 8) chk("addr", hd[i-1], addr);
         if (i > 57) chk("addr", tl[i-58], addr);
      end
      chk("bank page", 12'h000, rom[11:6]);
   endtask
   task automatic t_halt;
      halt_n = 1'h0;
      {branch, status} = 2'h2;
      cyc(7);
      chk("addr", 6'h3D, addr);
      chk("run", 1'h0, run);
      chk("sset", 1'h1, sset);
      {halt_n, branch} = 2'h2;
      cyc(2);
      chk("addr", 6'h3D, addr);
      chk("sset", 1'h1, sset);
      cyc(1);
      chk("addr", 6'h3B, addr);
      chk("sset", 1'h0, sset);
      chk("run", 1'h1, run);
   endtask
   task automatic t_branch;
      branch = 1'h1;
      status = 1'h1;
      instr = 10'h2A5;
      cyc(1);
      chk("addr", 6'h25, addr);
      status = 1'h0;
      cyc(1);
      chk("addr", 6'h0A, addr);
      chk("sset", 1'h1, sset);
      branch = 1'h0;
      cyc(1);
      chk("sset", 1'h0, sset);
   endtask
   task automatic t_long;
      chk("sub", 1'h1, sub);
      {load_bank_page_upper, status, bsel, instr} = {3'h6, 10'h01F};
      cyc(1);
      chk("bank page", 12'h000, rom[11:6]);
      {load_bank_page_upper, branch, instr} = {2'h1, 10'h000};
      cyc(1);
      chk("rom", 12'hFC0, rom);
      chk("sub", 1'h0, sub);
      chk("bank", 1'h1, bank);
      chk("page", 5'h1F, page);
      {branch, load_bank_page_upper, status, bsel, instr} = {4'h5, 10'h005};
      cyc(3);
      load_bank_page_upper = 1'h0;
      chk("bank page", 12'h03F, rom[11:6]);
   endtask
   task automatic t_int;
      want = 2'h1;
      cyc(5);
      chk("ints", 2'h1, {ib, ia});
      want = 2'h2;
      cyc(5);
      chk("ints", 2'h2, {ib, ia});
   endtask
   task automatic t_reset;
      srst_in = 1'h1;
      cyc(3);
      chk("rom", 12'h03F, rom);
      chk("ints", 2'h0, {ib, ia});
      chk("run", 1'h0, run);
      srst_in = 1'h0;
      cyc(1);
      chk("addr", 6'h3E, addr);
      chk("run", 1'h1, run);
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      cyc(6);
      chk("rom", 12'h03F, rom);
      srst_in = 1'h0;
      t_walk();
      t_halt();
      t_branch();
      t_long();
      t_int();
      t_reset();
      results();
   end
endmodule // tb_top
`default_nettype wire
